// file: inc/rbac_consts.vh
// Constants for the contactless block access checker
// Assumes inclusion by bare name from the design files
`ifndef RBAC_CONSTS_VH
`define RBAC_CONSTS_VH

// =====================================================
// Memory map
`define RBAC_ADDR_W 9
`define RBAC_NUM_BLOCKS 32
`define RBAC_BLOCK_SHIFT 4
`define RBAC_LAST_USER_BLOCK 5'h1a
`define RBAC_FIRST_CFG_BLOCK 5'h1b
`define RBAC_LAST_CFG_BLOCK 5'h1d

// =====================================================
// Register offsets
`define RBAC_WLOCK0_OFS 9'h1f0
`define RBAC_WLOCK1_OFS 9'h1f1
`define RBAC_WLOCK2_OFS 9'h1f2
`define RBAC_WLOCK3_OFS 9'h1f3
`define RBAC_GUARD0_OFS 9'h1f8
`define RBAC_GUARD1_OFS 9'h1f9
`define RBAC_GUARD2_OFS 9'h1fa
`define RBAC_GUARD3_OFS 9'h1fb
`define RBAC_STATUS_OFS 9'h1fe
`define RBAC_CTRL_OFS 9'h1ff

// =====================================================
// Fields and reset values
`define RBAC_LAST_BYTE_MASK 8'h07
`define RBAC_BITS_RESET 8'h00
`define RBAC_CTRL_RESET 8'h01
`define RBAC_CTRL_RF_EN_BIT 0

// =====================================================
// Verdict codes
`define RBAC_VERDICT_W 2
`define RBAC_V_DENY 2'h0
`define RBAC_V_RO 2'h1
`define RBAC_V_RW 2'h2

`endif

// file: src/rbac_decode.v
// Address decoder: byte address to block number and area class
// Assumes a 9-bit byte address into a 512-byte map
`timescale 1ns/1ns
`include "rbac_consts.vh"

module rbac_decode
(
    input wire [`RBAC_ADDR_W-1:0] addr,
    output wire [4:0] block,
    output wire is_user,
    output wire is_cfg
);

    assign block = addr[`RBAC_ADDR_W-1:`RBAC_BLOCK_SHIFT]; // RQ1
    assign is_user = (block <= `RBAC_LAST_USER_BLOCK); // RQ2
    assign is_cfg = (block >= `RBAC_FIRST_CFG_BLOCK) && (block <= `RBAC_LAST_CFG_BLOCK); // RQ3

endmodule

// file: src/rbac_perm.v
// Permission table: guard and write-lock bit to read/write verdict
// Assumes both bits already selected for the target block
`timescale 1ns/1ns
`include "rbac_consts.vh"

module rbac_perm
(
    input wire guard,
    input wire lock,
    input wire encrypted,
    output reg [`RBAC_VERDICT_W-1:0] verdict
);

    always @*
    begin
        case ({guard, lock})
            2'h0: verdict = `RBAC_V_RW; // RQ7
            2'h1: verdict = encrypted ? `RBAC_V_RW : `RBAC_V_DENY; // RQ8
            2'h2: verdict = `RBAC_V_RO; // RQ9
            default: verdict = encrypted ? `RBAC_V_RW : `RBAC_V_RO; // RQ10
        endcase
    end

endmodule

// file: src/rbac_checker.v
// Access checker for contactless memory access commands
// Assumes synchronous inputs on ref_clk and one-cycle strobes
//
// Notes on behaviour
// RQ1 - 32 blocks of 16 bytes each
// RQ2 - Blocks 0 to 26 are user storage
// RQ3 - Blocks 27 to 29 are configuration storage
// RQ4 - Four lock bytes act in contactless mode only
// RQ5 - Lock and guard bits reset to zero
// RQ6 - Software writes zero to reserved bits
// RQ7 - Guard 0 lock 0: full access
// RQ8 - Guard 0 lock 1: encrypted only
// RQ9 - Guard 1 lock 0: read only
// RQ10 - Both set: plaintext reads, encrypted full
// RQ11 - Lock bit k at byte k/8, bit k%8
// RQ12 - Last byte bits 0-2 used, rest reserved
// RQ13 - Check first; refused access leaves memory unchanged
// RQ14 - Guard bytes at 0x1f8, same layout
`timescale 1ns/1ns
`include "rbac_consts.vh"

module rbac_checker
(
    input wire ref_clk,
    input wire reset_n,
    input wire [8:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire acc_req,
    input wire acc_write,
    input wire acc_encrypted,
    input wire acc_rf_mode,
    input wire [8:0] acc_addr,
    output reg acc_done,
    output reg acc_grant,
    output reg acc_error,
    output reg mem_we,
    output reg [8:0] mem_addr
);

    // =====================================================
    // Local copies of the map constants
    localparam [8:0] LOCK_BASE = `RBAC_WLOCK0_OFS;
    localparam [8:0] GUARD_BASE = `RBAC_GUARD0_OFS;
    localparam [8:0] STATUS_ADDR = `RBAC_STATUS_OFS;
    localparam [8:0] CTRL_ADDR = `RBAC_CTRL_OFS;
    localparam [7:0] LAST_MASK = `RBAC_LAST_BYTE_MASK;
    localparam [7:0] BITS_RESET = `RBAC_BITS_RESET;
    localparam [7:0] CTRL_RESET = `RBAC_CTRL_RESET;
    localparam [7:0] CTRL_WR_MASK = 8'h01;
    localparam [7:0] DENY_MAX = 8'hff;
    localparam [8:0] MEM_ADDR_RESET = 9'h000;

    // =====================================================
    // Lock and guard bit storage
    wire [31:0] rf_write_lock_bits;
    wire [31:0] plaintext_guard_bits;
    reg [7:0] ctrl_q;
    reg [7:0] deny_cnt_q;
    reg [7:0] deny_cnt_d;
    reg last_error_q;
    reg last_error_d;
    reg [7:0] rdata_d;
    // Next values of the access answers
    reg done_d;
    reg grant_d;
    reg error_d;
    reg we_d;
    reg [8:0] mem_addr_d;

    // =====================================================
    // Register bus decode
    wire [1:0] byte_sel;
    wire [3:0] byte_hit;
    wire is_lock;
    wire is_guard;
    wire is_status;
    wire is_ctrl;
    wire [7:0] wmask;
    wire [7:0] lock_byte;
    wire [7:0] guard_byte;

    // Lock and guard bytes share one word layout
    assign byte_sel = reg_addr[1:0];
    assign byte_hit = 4'h1 << byte_sel;
    assign is_lock = (reg_addr[8:2] == LOCK_BASE[8:2]); // RQ11
    assign is_guard = (reg_addr[8:2] == GUARD_BASE[8:2]); // RQ14
    assign is_status = (reg_addr == STATUS_ADDR);
    assign is_ctrl = (reg_addr == CTRL_ADDR);
    assign wmask = (byte_sel == 2'h3) ? LAST_MASK : 8'hff; // RQ12
    assign lock_byte = rf_write_lock_bits[{byte_sel, 3'h0} +: 8];
    assign guard_byte = plaintext_guard_bits[{byte_sel, 3'h0} +: 8];

    // =====================================================
    // Per-byte lock and guard registers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_bytes
            reg [7:0] lock_byte_q;
            reg [7:0] guard_byte_q;

            always @(posedge ref_clk)
            begin
                if (!reset_n)
                begin
                    lock_byte_q <= BITS_RESET; // RQ5
                    guard_byte_q <= BITS_RESET; // RQ5
                end
                else if (reg_wr && byte_hit[gi])
                begin
                    // Reserved bits stay zero regardless of what is written
                    if (is_lock)
                    begin
                        lock_byte_q <= reg_wdata & wmask; // RQ11 RQ6
                    end
                    if (is_guard)
                    begin
                        guard_byte_q <= reg_wdata & wmask; // RQ14
                    end
                end
            end

            assign rf_write_lock_bits[gi*8 +: 8] = lock_byte_q;
            assign plaintext_guard_bits[gi*8 +: 8] = guard_byte_q;
        end
    endgenerate

    // =====================================================
    // Control register
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (reg_wr && is_ctrl)
        begin
            ctrl_q <= reg_wdata & CTRL_WR_MASK;
        end
    end

    // =====================================================
    // Register read port
    // Unmapped addresses and idle cycles read as zero
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            if (is_lock)
            begin
                rdata_d = lock_byte;
            end
            else if (is_guard)
            begin
                rdata_d = guard_byte;
            end
            else if (is_status)
            begin
                rdata_d = deny_cnt_q;
            end
            else if (is_ctrl)
            begin
                rdata_d = {6'h00, last_error_q, ctrl_q[`RBAC_CTRL_RF_EN_BIT]};
            end
        end
    end

    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_d;
        end
    end

    // =====================================================
    // Access evaluation
    wire [4:0] blk;
    wire blk_user;
    wire blk_cfg;
    wire [1:0] verdict;
    wire lock_bit;
    wire guard_bit;
    wire rf_active;
    reg allow;

    // Bits of the target block
    assign lock_bit = rf_write_lock_bits[blk]; // RQ11
    assign guard_bit = plaintext_guard_bits[blk]; // RQ14
    assign rf_active = acc_rf_mode && ctrl_q[`RBAC_CTRL_RF_EN_BIT]; // RQ4

    // Block number and area class
    rbac_decode u_dec
    (
        .addr(acc_addr),
        .block(blk),
        .is_user(blk_user),
        .is_cfg(blk_cfg)
    );

    // Verdict of the table for this block
    rbac_perm u_perm
    (
        .guard(guard_bit),
        .lock(lock_bit),
        .encrypted(acc_encrypted),
        .verdict(verdict)
    );

    // =====================================================
    // Permission decision
    always @*
    begin
        allow = 1'b1;
        if (blk_cfg)
        begin
            allow = 1'b0; // RQ3
        end
        else if (!blk_user)
        begin
            // System blocks are never open to memory access commands
            allow = 1'b0;
        end
        else if (rf_active) // RQ4
        begin
            if (verdict == `RBAC_V_DENY)
            begin
                allow = 1'b0; // RQ8
            end
            else if (verdict == `RBAC_V_RO && acc_write)
            begin
                allow = 1'b0; // RQ9
            end
        end
    end

    // =====================================================
    // Next values of the answers
    // Address and refusal flag hold between accesses
    always @*
    begin
        done_d = acc_req;
        grant_d = acc_req && allow;
        error_d = acc_req && !allow; // RQ13
        we_d = acc_req && allow && acc_write; // RQ13
        mem_addr_d = mem_addr;
        last_error_d = last_error_q;
        deny_cnt_d = deny_cnt_q;
        if (acc_req)
        begin
            mem_addr_d = acc_addr; // RQ1
            last_error_d = !allow;
            if (!allow && deny_cnt_q != DENY_MAX)
            begin
                deny_cnt_d = deny_cnt_q + 8'h01;
            end
        end
    end

    // =====================================================
    // Answer registers
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            acc_done <= 1'b0;
            acc_grant <= 1'b0;
            acc_error <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= MEM_ADDR_RESET;
        end
        else
        begin
            acc_done <= done_d;
            acc_grant <= grant_d;
            acc_error <= error_d;
            mem_we <= we_d;
            mem_addr <= mem_addr_d;
        end
    end

    // =====================================================
    // Refusal counter and last refusal flag
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            deny_cnt_q <= 8'h00;
            last_error_q <= 1'b0;
        end
        else
        begin
            deny_cnt_q <= deny_cnt_d;
            last_error_q <= last_error_d;
        end
    end

endmodule

// file: tb/rbac_monitor.sv
// Assertions on the access port of the block checker
// Assumes binding onto rbac_checker, one clock
`timescale 1ns/1ns
module rbac_monitor
(
    input wire ref_clk,
    input wire reset_n,
    input wire acc_req,
    input wire acc_write,
    input wire acc_rf_mode,
    input wire [8:0] acc_addr,
    input wire acc_done,
    input wire acc_grant,
    input wire acc_error,
    input wire mem_we,
    input wire [8:0] mem_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // Access answers
    sequence s_wr_ok;
        acc_req && acc_write ##1 acc_grant;
    endsequence
    property p_done; acc_req |=> acc_done; endproperty
    property p_idle; !acc_req |=> !acc_done; endproperty
    property p_one; acc_grant || acc_error |-> acc_done && (acc_grant != acc_error); endproperty
    property p_addr; acc_req |=> mem_addr == $past(acc_addr); endproperty
    property p_cfg; acc_req && acc_addr[8:4] > 5'h1a |=> acc_error; endproperty
    property p_free; acc_req && !acc_rf_mode && acc_addr[8:4] < 5'h1b |=> acc_grant; endproperty
    property p_we; mem_we |-> $past(acc_req) && $past(acc_write) && acc_grant; endproperty
    property p_commit; s_wr_ok |-> mem_we; endproperty
    a_done: assert property (p_done) else $error("No answer to access");
    a_idle: assert property (p_idle) else $error("Answer without access");
    a_one: assert property (p_one) else $error("Grant and error clash");
    a_addr: assert property (p_addr) else $error("Wrong memory address");
    a_cfg: assert property (p_cfg) else $error("Config block not refused");
    a_free: assert property (p_free) else $error("Unchecked access refused");
    a_we: assert property (p_we) else $error("Write without grant");
    a_commit: assert property (p_commit) else $error("Granted write lost");
endmodule
bind rbac_checker rbac_monitor u_mon (.*);

// file: tb/rbac_reader.sv
// Contactless reader model issuing access commands
// Assumes the caller samples the answer after cmd
`timescale 1ns/1ns
module rbac_reader
(
    input wire ref_clk,
    output reg acc_req,
    output reg acc_write,
    output reg acc_encrypted,
    output reg acc_rf_mode,
    output reg [8:0] acc_addr
);
    initial {acc_req, acc_write, acc_encrypted, acc_rf_mode, acc_addr} = 13'h0000;
    task cmd(input w, input e, input rf, input [8:0] a);
    begin
        @(posedge ref_clk);
        acc_req <= 1'b1;
        {acc_write, acc_encrypted, acc_rf_mode, acc_addr} <= {w, e, rf, a};
        @(posedge ref_clk);
        acc_req <= 1'b0;
        // Released lines do not keep their value
        {acc_write, acc_encrypted, acc_rf_mode, acc_addr} <= ~{w, e, rf, a};
    end
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the block access checker
// Assumes the reader model on the access port
`timescale 1ns/1ns
module tb_top;
    reg ref_clk, reset_n, reg_wr, reg_rd;
    reg [8:0] reg_addr;
    reg [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire acc_req, acc_write, acc_encrypted, acc_rf_mode, acc_done, acc_grant, acc_error, mem_we;
    wire [8:0] acc_addr, mem_addr;
    integer miscompares = 0, checks = 0, cycles = 0, i;
    reg [15:0] tbl = 16'hd5cf;
    rbac_checker dut (.*);
    rbac_reader rdr (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ==========================================
    // Tasks
    task end_of_test;
    begin
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task chk(input [8:0] got, input [8:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            miscompares = miscompares + 1;
    end
    endtask
    task wr(input [8:0] a, input [7:0] d);
    begin
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [8:0] a, input [7:0] e);
    begin
        @(posedge ref_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    end
    endtask
    // Mode bits: write, encrypted, contactless, expected grant
    task acc(input [3:0] m, input [8:0] a);
    begin
        rdr.cmd(m[3], m[2], m[1], a);
        #1;
        chk({acc_done, acc_grant, acc_error, mem_we}, {1'b1, m[0], !m[0], m[0] & m[3]});
        chk(mem_addr, a);
    end
    endtask
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    // ==========================================
    // Tests
    initial
    begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 20'h00000;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            rd(9'h1f0 + i[8:0], 8'h00);
            rd(9'h1f8 + i[8:0], 8'h00);
        end
        wr(9'h1f4, 8'hff);
        rd(9'h1f4, 8'h00);
        wr(9'h1f3, 8'hff);
        rd(9'h1f3, 8'h07);
        wr(9'h1fb, 8'hff);
        rd(9'h1fb, 8'h07);
        acc(4'b1010, 9'h1af);
        acc(4'b0011, 9'h1a0);
        acc(4'b1001, 9'h1af);
        acc(4'b1111, 9'h19f);
        for (i = 27; i < 32; i = i + 1)
            acc(4'b0100, {i[4:0], 4'h0});
        wr(9'h1f3, 8'h00);
        wr(9'h1fb, 8'h00);
        wr(9'h1f2, 8'h80);
        acc(4'b1010, 9'h170);
        acc(4'b1011, 9'h16f);
        wr(9'h1f2, 8'h00);
        for (i = 0; i < 16; i = i + 1)
        begin
            wr(9'h1f0, {6'h00, i[2], 1'b0});
            wr(9'h1f8, {6'h00, i[3], 1'b0});
            acc({i[0], i[1], 1'b1, tbl[i]}, 9'h01f);
            acc(4'b1011, 9'h00f);
        end
        rd(9'h1fe, 8'h0c);
        rd(9'h1ff, 8'h01);
        wr(9'h1ff, 8'h00);
        wr(9'h1f0, 8'h01);
        acc(4'b1011, 9'h00f);
        rd(9'h1ff, 8'h00);
        acc(4'b0010, 9'h1b0);
        rd(9'h1ff, 8'h02);
        wr(9'h1ff, 8'h01);
        acc(4'b1010, 9'h00f);
        rd(9'h1fe, 8'h0e);
        end_of_test;
    end
endmodule
